// ==== dcr_config_regs.sv ====
// Converter configuration register bank with serial port and pattern generator
//
// Operation
// - Pattern enable feeds the converter from the 64-sample pattern memory.
// - Pattern bytes travel MSB first; each sample is assembled in that order.
// - Reading the pattern data location shifts stored bytes out, advancing each byte.
// - Pattern control and pattern data reset to zero.
// - Writing one to software reset returns every register to reset value.
// - Core power-down stops the converter core; full power-down also stops the core, the sample clock receiver and output clock ticks.
// - Resolution code is read-only and reads zero under full power-down.
// - Clock bit 0 disables sample clock receiver; bit 1 shows clock presence.
// - Clock bit 4 disables the data clock output driver.
// - Clock bit 5 picks output clock at sample rate over four or two.
// - Clock bit 6 picks drive current; bit 7 enables output termination.
// - Input clock bit 0 enables receiver; bit 1 shows incoming clock detected.
// - Input clock bit 2 picks quadrature; bits 6:4 hold delay, reset zero.
// - Data port bits 0 and 1 enable port A and port B receivers.
// - Data port bit 2 selects single-port when set, dual-port when clear.
// - Data port bit 3 clear forces the converter output to mid-scale.
// - Sync phase field automatic unless manual bit set, then host value.
// - Offset six reads the phase comparator outputs, zero after reset.
`timescale 1ns/10ps
module dcr_config_regs
  import dcr_pkg::*;
#(
  parameter logic [1:0] RESOLUTION_CODE = 2'b00
)
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  // Serial port
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  output logic sdo_o,
  // Converter datapath
  input wire logic sample_tick_i,
  input wire logic [15:0] port_data_i,
  output logic [15:0] dac_code_o,
  output logic outclk_tick_o,
  // Analogue status
  input wire logic sample_clock_present_i,
  input wire logic inclk_present_i,
  input wire logic [1:0] sync_auto_phase_i,
  input wire logic [7:0] phase_comparator_bits_i,
  // Analogue controls
  output logic core_power_down_o,
  output logic device_power_down_o,
  output logic sample_clock_rx_off_o,
  output logic outclk_disable_o,
  output logic outclk_divider_select_o,
  output logic outclk_drive_select_o,
  output logic outclk_termination_o,
  output logic inclk_rx_enable_o,
  output logic inclk_quadrature_o,
  output logic [2:0] inclk_delay_adjust_o,
  output logic port_a_rx_enable_o,
  output logic port_b_rx_enable_o,
  output logic single_port_select_o,
  output logic [1:0] sync_phase_select_o,
  output logic pattern_enable_o
);
  // ----------------------------------------------------------------
  // Serial port
  // ----------------------------------------------------------------
  logic rw;
  logic [6:0] addr;
  logic wr;
  logic [7:0] wdata;
  logic rd_req;
  logic [7:0] rd_data;

  dcr_spi_slave u_spi (
    .ref_clk_i(ref_clk_i),
    .rst_n_i(rst_n_i),
    .sck_i(sck_i),
    .cs_n_i(cs_n_i),
    .sdi_i(sdi_i),
    .ld_data_i(rd_data),
    .sdo_o(sdo_o),
    .rw_o(rw),
    .addr_o(addr),
    .wr_o(wr),
    .wdata_o(wdata),
    .rd_req_o(rd_req)
  );

  function automatic logic hit(input logic [6:0] a, input logic [6:0] target);
    hit = (a == target);
  endfunction

  // ----------------------------------------------------------------
  // Register storage
  // ----------------------------------------------------------------
  logic soft_rst_q;
  logic clr;
  logic core_pd_q;
  logic dev_pd_q;
  logic sclk_off_q;
  logic oclk_dis_q;
  logic oclk_div_q;
  logic oclk_drv_q;
  logic oclk_trm_q;
  logic iclk_en_q;
  logic iclk_quad_q;
  logic [2:0] iclk_dly_q;
  logic port_a_q;
  logic port_b_q;
  logic single_q;
  logic data_en_q;
  logic [1:0] sync_phase_select_q;
  logic sync_man_q;
  logic pat_en_q;
  logic [7:0] phase_q;

  // Software reset acts one cycle after the write and clears all but the serial port and the clock presence synchronisers
  assign clr = !rst_n_i || soft_rst_q;

  wire wr_power = wr && hit(addr, DCR_ADDR_RESET_POWER);
  wire wr_clock = wr && hit(addr, DCR_ADDR_CLOCK_IO);
  wire wr_inclk = wr && hit(addr, DCR_ADDR_INCLK);
  wire wr_port = wr && hit(addr, DCR_ADDR_DATA_PORT);
  wire wr_sync = wr && hit(addr, DCR_ADDR_SYNC);
  wire wr_pctl = wr && hit(addr, DCR_ADDR_PAT_CTRL);
  wire wr_pdat = wr && hit(addr, DCR_ADDR_PAT_DATA);
  logic rd_open_q;
  // Only reloads after a data byte move the pointer; the command prefetch would leave it odd
  wire rd_pdat = rd_req && rw && rd_open_q && hit(addr, DCR_ADDR_PAT_DATA);

  always_ff @(posedge ref_clk_i)
  begin
    if (clr || cs_n_i)
      rd_open_q <= 1'b0;
    else if (rd_req)
      rd_open_q <= 1'b1;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
      soft_rst_q <= 1'b0;
    else
      soft_rst_q <= wr_power && wdata[DCR_BIT_SW_RESET] && !soft_rst_q;
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr || wr_power)
    begin
      core_pd_q <= !clr && !wdata[DCR_BIT_SW_RESET] && wdata[DCR_BIT_CORE_PD];
      dev_pd_q <= !clr && !wdata[DCR_BIT_SW_RESET] && wdata[DCR_BIT_DEVICE_PD];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
    begin
      sclk_off_q <= 1'b0;
      oclk_dis_q <= 1'b0;
      oclk_div_q <= 1'b0;
      oclk_drv_q <= 1'b0;
      oclk_trm_q <= 1'b0;
    end
    else if (wr_clock)
    begin
      sclk_off_q <= wdata[DCR_BIT_SCLK_OFF];
      oclk_dis_q <= wdata[DCR_BIT_OCLK_DIS];
      oclk_div_q <= wdata[DCR_BIT_OCLK_DIV];
      oclk_drv_q <= wdata[DCR_BIT_OCLK_DRV];
      oclk_trm_q <= wdata[DCR_BIT_OCLK_TRM];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
    begin
      iclk_en_q <= 1'b0;
      iclk_quad_q <= 1'b0;
      iclk_dly_q <= 3'h0;
    end
    else if (wr_inclk)
    begin
      iclk_en_q <= wdata[DCR_BIT_ICLK_EN];
      iclk_quad_q <= wdata[DCR_BIT_ICLK_QUAD];
      iclk_dly_q <= wdata[DCR_BIT_ICLK_DLY_LO +: 3];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
    begin
      port_a_q <= 1'b0;
      port_b_q <= 1'b0;
      single_q <= 1'b0;
      data_en_q <= 1'b0;
    end
    else if (wr_port)
    begin
      port_a_q <= wdata[DCR_BIT_PORT_A_EN];
      port_b_q <= wdata[DCR_BIT_PORT_B_EN];
      single_q <= wdata[DCR_BIT_SINGLE_PORT];
      data_en_q <= wdata[DCR_BIT_DATA_EN];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
    begin
      sync_phase_select_q <= 2'b00;
      sync_man_q <= 1'b0;
    end
    else if (wr_sync)
    begin
      sync_phase_select_q <= wdata[DCR_BIT_SYNC_MANUAL-1:0];
      sync_man_q <= wdata[DCR_BIT_SYNC_MANUAL];
    end
  end

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      pat_en_q <= 1'b0;
    else if (wr_pctl)
      pat_en_q <= wdata[DCR_BIT_PAT_EN];
  end

  // Comparator outputs are captured each cycle so a read sees a stable byte
  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      phase_q <= DCR_RESET_BYTE;
    else
      phase_q <= phase_comparator_bits_i;
  end

  // ----------------------------------------------------------------
  // Clock presence synchronisers
  // ----------------------------------------------------------------
  logic [1:0] sclk_ok_sync_q;
  logic [1:0] iclk_ok_sync_q;

  // Plain level follow-through: no sticky bit, so a lost clock shows after the two-flop delay
  always_ff @(posedge ref_clk_i)
  begin
    if (!rst_n_i)
    begin
      sclk_ok_sync_q <= 2'b00;
      iclk_ok_sync_q <= 2'b00;
    end
    else
    begin
      sclk_ok_sync_q <= {sclk_ok_sync_q[0], sample_clock_present_i};
      iclk_ok_sync_q <= {iclk_ok_sync_q[0], inclk_present_i};
    end
  end

  wire sclk_ok = sclk_ok_sync_q[1] && !sclk_off_q;
  wire iclk_ok = iclk_ok_sync_q[1] && iclk_en_q;

  // ----------------------------------------------------------------
  // Pattern memory
  // ----------------------------------------------------------------
  logic [7:0] pat_byte;
  logic [15:0] pat_sample;
  wire play = sample_tick_i && pat_en_q && !dev_pd_q && !core_pd_q;

  // Host must not touch the data location while the pattern runs; the memory is shared, the pointers are separate
  dcr_pattern_mem #(
    .SAMPLES(DCR_PAT_SAMPLES)
  ) u_pat (
    .ref_clk_i(ref_clk_i),
    .clr_i(clr),
    .wr_i(wr_pdat),
    .pop_i(rd_pdat),
    .wdata_i(wdata),
    .play_i(play),
    .rd_byte_o(pat_byte),
    .sample_o(pat_sample)
  );

  // ----------------------------------------------------------------
  // Readback
  // ----------------------------------------------------------------
  wire [1:0] res_code = dev_pd_q ? 2'b00 : RESOLUTION_CODE;
  wire [1:0] sync_eff = sync_man_q ? sync_phase_select_q : sync_auto_phase_i;

  wire [7:0] rd_power = {2'b00, res_code, 1'b0, dev_pd_q, core_pd_q, 1'b0};
  wire [7:0] rd_clock = {oclk_trm_q, oclk_drv_q, oclk_div_q, oclk_dis_q, 2'b00, sclk_ok, sclk_off_q};
  wire [7:0] rd_inclk = {1'b0, iclk_dly_q, 1'b0, iclk_quad_q, iclk_ok, iclk_en_q};
  wire [7:0] rd_port = {4'h0, data_en_q, single_q, port_b_q, port_a_q};
  wire [7:0] rd_sync = {5'h00, sync_man_q, sync_eff};
  wire [7:0] rd_pctl = {7'h00, pat_en_q};

  always_comb
  begin
    case (addr)
      DCR_ADDR_RESET_POWER: rd_data = rd_power;
      DCR_ADDR_CLOCK_IO: rd_data = rd_clock;
      DCR_ADDR_INCLK: rd_data = rd_inclk;
      DCR_ADDR_DATA_PORT: rd_data = rd_port;
      DCR_ADDR_SYNC: rd_data = rd_sync;
      DCR_ADDR_PHASE_CMP: rd_data = phase_q;
      DCR_ADDR_PAT_CTRL: rd_data = rd_pctl;
      DCR_ADDR_PAT_DATA: rd_data = pat_byte;
      default: rd_data = DCR_RESET_BYTE;
    endcase
  end

  // ----------------------------------------------------------------
  // Data clock output divider
  // ----------------------------------------------------------------
  logic [2:0] oclk_cnt_q;
  logic oclk_tick_q;
  wire [2:0] oclk_last = oclk_div_q ? DCR_OCLK_DIV2_LAST : DCR_OCLK_DIV4_LAST;
  wire oclk_run = !oclk_dis_q && !dev_pd_q && !sclk_off_q;

  always_ff @(posedge ref_clk_i)
  begin
    oclk_tick_q <= 1'b0;
    if (clr || !oclk_run)
      oclk_cnt_q <= 3'h0;
    else if (sample_tick_i)
    begin
      if (oclk_cnt_q >= oclk_last)
      begin
        oclk_cnt_q <= 3'h0;
        oclk_tick_q <= 1'b1;
      end
      else
        oclk_cnt_q <= oclk_cnt_q + 3'h1;
    end
  end

  assign outclk_tick_o = oclk_tick_q;

  // ----------------------------------------------------------------
  // Converter code selection
  // ----------------------------------------------------------------
  logic [15:0] code_q;
  wire [15:0] code_src = pat_en_q ? pat_sample : port_data_i;
  wire [15:0] code_d = data_en_q ? code_src : DCR_MID_SCALE;

  always_ff @(posedge ref_clk_i)
  begin
    if (clr)
      code_q <= DCR_MID_SCALE;
    else if (sample_tick_i)
      code_q <= code_d;
  end

  assign dac_code_o = code_q;

  // ----------------------------------------------------------------
  // Control outputs
  // ----------------------------------------------------------------
  assign core_power_down_o = core_pd_q || dev_pd_q;
  assign device_power_down_o = dev_pd_q;
  assign sample_clock_rx_off_o = sclk_off_q || dev_pd_q;
  assign outclk_disable_o = oclk_dis_q;
  assign outclk_divider_select_o = oclk_div_q;
  assign outclk_drive_select_o = oclk_drv_q;
  assign outclk_termination_o = oclk_trm_q;
  assign inclk_rx_enable_o = iclk_en_q;
  assign inclk_quadrature_o = iclk_quad_q;
  assign inclk_delay_adjust_o = iclk_dly_q;
  assign port_a_rx_enable_o = port_a_q;
  assign port_b_rx_enable_o = port_b_q;
  assign single_port_select_o = single_q;
  assign sync_phase_select_o = sync_eff;
  assign pattern_enable_o = pat_en_q;
endmodule

// ==== dcr_pkg.sv ====
// Shared constants for the converter configuration register bank
package dcr_pkg;
  // Register offsets (7-bit serial address space)
  localparam logic [6:0] DCR_ADDR_RSVD0 = 7'h00;
  localparam logic [6:0] DCR_ADDR_RESET_POWER = 7'h01;
  localparam logic [6:0] DCR_ADDR_CLOCK_IO = 7'h02;
  localparam logic [6:0] DCR_ADDR_INCLK = 7'h03;
  localparam logic [6:0] DCR_ADDR_DATA_PORT = 7'h04;
  localparam logic [6:0] DCR_ADDR_SYNC = 7'h05;
  localparam logic [6:0] DCR_ADDR_PHASE_CMP = 7'h06;
  localparam logic [6:0] DCR_ADDR_PAT_CTRL = 7'h1e;
  localparam logic [6:0] DCR_ADDR_PAT_DATA = 7'h1f;

  // Field positions
  localparam int DCR_BIT_SW_RESET = 0;
  localparam int DCR_BIT_CORE_PD = 1;
  localparam int DCR_BIT_DEVICE_PD = 2;
  localparam int DCR_BIT_RES_LO = 4;
  localparam int DCR_BIT_SCLK_OFF = 0;
  localparam int DCR_BIT_SCLK_OK = 1;
  localparam int DCR_BIT_OCLK_DIS = 4;
  localparam int DCR_BIT_OCLK_DIV = 5;
  localparam int DCR_BIT_OCLK_DRV = 6;
  localparam int DCR_BIT_OCLK_TRM = 7;
  localparam int DCR_BIT_ICLK_EN = 0;
  localparam int DCR_BIT_ICLK_OK = 1;
  localparam int DCR_BIT_ICLK_QUAD = 2;
  localparam int DCR_BIT_ICLK_DLY_LO = 4;
  localparam int DCR_BIT_PORT_A_EN = 0;
  localparam int DCR_BIT_PORT_B_EN = 1;
  localparam int DCR_BIT_SINGLE_PORT = 2;
  localparam int DCR_BIT_DATA_EN = 3;
  localparam int DCR_BIT_SYNC_MANUAL = 2;
  localparam int DCR_BIT_PAT_EN = 0;

  // Reset values and constants
  localparam logic [7:0] DCR_RESET_BYTE = 8'h00;
  localparam logic [15:0] DCR_MID_SCALE = 16'h8000;
  localparam logic [2:0] DCR_OCLK_DIV4_LAST = 3'h3;
  localparam logic [2:0] DCR_OCLK_DIV2_LAST = 3'h1;
  localparam int DCR_PAT_SAMPLES = 64;
  localparam int DCR_PAT_BYTES = 2 * DCR_PAT_SAMPLES;
endpackage

// ==== dcr_spi_slave.sv ====
// Serial port slave: command byte then data bytes, mode 0, sampled on the system clock
`timescale 1ns/10ps
module dcr_spi_slave
  import dcr_pkg::*;
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic sck_i,
  input wire logic cs_n_i,
  input wire logic sdi_i,
  input wire logic [7:0] ld_data_i,
  output logic sdo_o,
  output logic rw_o,
  output logic [6:0] addr_o,
  output logic wr_o,
  output logic [7:0] wdata_o,
  output logic rd_req_o
);
  logic sck_q;
  logic first_q;
  logic [2:0] cnt_q;
  logic [6:0] sh_q;
  logic [7:0] out_q;
  wire rise = sck_i & ~sck_q & ~cs_n_i;
  wire fall = ~sck_i & sck_q & ~cs_n_i;
  wire byte_done = rise && (cnt_q == 3'h7);
  wire [7:0] byte_in = {sh_q, sdi_i};

  assign sdo_o = out_q[7];

  // SCK is slow against the system clock, so a one-flop edge detect is enough
  always_ff @(posedge ref_clk_i)
  begin
    wr_o <= 1'b0;
    rd_req_o <= 1'b0;
    if (!rst_n_i)
    begin
      sck_q <= 1'b0;
      first_q <= 1'b1;
      cnt_q <= 3'h0;
      sh_q <= 7'h00;
      out_q <= 8'h00;
      rw_o <= 1'b0;
      addr_o <= 7'h00;
      wdata_o <= 8'h00;
    end
    else
    begin
      sck_q <= sck_i;
      if (cs_n_i)
      begin
        first_q <= 1'b1;
        cnt_q <= 3'h0;
      end
      else if (rise)
      begin
        sh_q <= byte_in[6:0];
        cnt_q <= cnt_q + 3'h1;
        if (byte_done && first_q)
        begin
          first_q <= 1'b0;
          rw_o <= byte_in[7];
          addr_o <= byte_in[6:0];
          rd_req_o <= byte_in[7];
        end
        else if (byte_done)
        begin
          wdata_o <= byte_in;
          wr_o <= ~rw_o;
          rd_req_o <= rw_o;
        end
      end
      // Shifting only inside a byte keeps a freshly loaded MSB for the next rise
      if (rd_req_o)
        out_q <= ld_data_i;
      else if (fall && cnt_q != 3'h0)
        out_q <= {out_q[6:0], 1'b0};
    end
  end
endmodule

// ==== dcr_pattern_mem.sv ====
// Pattern memory: byte-wide serial load and readback, 16-bit sample playback
`timescale 1ns/10ps
module dcr_pattern_mem
  import dcr_pkg::*;
#(
  parameter int SAMPLES = DCR_PAT_SAMPLES
)
(
  input wire logic ref_clk_i,
  input wire logic clr_i,
  input wire logic wr_i,
  input wire logic pop_i,
  input wire logic [7:0] wdata_i,
  input wire logic play_i,
  output logic [7:0] rd_byte_o,
  output logic [15:0] sample_o
);
  localparam int BYTES = 2 * SAMPLES;
  localparam int PW = $clog2(BYTES);
  if (SAMPLES < 2 || (SAMPLES & (SAMPLES - 1)) != 0)
  begin
    $error("dcr_pattern_mem: SAMPLES must be a power of two");
  end
  logic [7:0] mem_q [BYTES];
  logic [PW-1:0] ptr_q;
  logic [PW-2:0] idx_q;
  wire [PW-1:0] even_a = {idx_q, 1'b0};
  wire [PW-1:0] odd_a = {idx_q, 1'b1};
  wire [PW-1:0] next_a = ptr_q + 1'b1;

  // A pop reloads the serial shifter in the same cycle, so it must see the byte after the pointer
  assign rd_byte_o = mem_q[pop_i ? next_a : ptr_q];
  // Sample shows ahead of the tick so the converter takes it on that very tick
  assign sample_o = {mem_q[even_a], mem_q[odd_a]};

  always_ff @(posedge ref_clk_i)
  begin
    if (clr_i)
    begin
      for (int i = 0; i < BYTES; i++)
        mem_q[i] <= DCR_RESET_BYTE;
      ptr_q <= '0;
      idx_q <= '0;
    end
    else
    begin
      if (wr_i)
        mem_q[ptr_q] <= wdata_i;
      if (wr_i || pop_i)
        ptr_q <= next_a;
      if (play_i)
        idx_q <= idx_q + 1'b1;
    end
  end
endmodule

// ==== dcr_config_regs_assertions.sv ====
// Port-level checker for the configuration register bank
`timescale 1ns/10ps
module dcr_config_regs_assertions
(
  input wire logic ref_clk_i,
  input wire logic rst_n_i,
  input wire logic cs_n_i,
  input wire logic sample_tick_i,
  input wire logic [15:0] port_data_i,
  input wire logic [15:0] dac_code_o,
  input wire logic outclk_tick_o,
  input wire logic core_power_down_o,
  input wire logic device_power_down_o,
  input wire logic sample_clock_rx_off_o,
  input wire logic pattern_enable_o,
  input wire logic outclk_disable_o,
  input wire logic port_a_rx_enable_o
);
  default clocking cb @(posedge ref_clk_i); endclocking
  default disable iff (!rst_n_i);
  logic [2:0] cfg;
  assign cfg = {pattern_enable_o, outclk_disable_o, port_a_rx_enable_o};
  a_device_power_down_all: assert property (device_power_down_o |-> core_power_down_o && sample_clock_rx_off_o)
    else $error("full power-down without core power-down");
  a_pd_no_tick: assert property (device_power_down_o && $past(device_power_down_o) |-> !outclk_tick_o)
    else $error("output clock tick while powered down");
  a_tick_single: assert property (outclk_tick_o |=> !outclk_tick_o)
    else $error("output clock tick longer than one cycle");
  a_tick_cause: assert property (outclk_tick_o |-> $past(sample_tick_i))
    else $error("output clock tick without sample tick");
  a_dac_on_tick: assert property ($changed(dac_code_o) |-> $past(sample_tick_i) || dac_code_o == 16'h8000)
    else $error("converter code changed off a sample tick");
  a_dac_port_path: assert property ($past(sample_tick_i) && !$past(pattern_enable_o) && dac_code_o != 16'h8000
    |-> dac_code_o == $past(port_data_i))
    else $error("converter code not from input port");
  a_reset_clear: assert property ($rose(rst_n_i) |-> cfg == 3'h0 && dac_code_o == 16'h8000)
    else $error("outputs not cleared by reset");
  a_idle_cfg_stable: assert property (cs_n_i && $past(cs_n_i) && $past(cs_n_i, 2) && $past(cs_n_i, 3)
    |-> $stable(cfg) && $stable(core_power_down_o))
    else $error("control changed with serial port idle");
  c_tick: cover property (outclk_tick_o);
  c_pattern_on: cover property ($rose(pattern_enable_o));
  c_device_power_down: cover property (device_power_down_o);
endmodule
bind dcr_config_regs dcr_config_regs_assertions u_chk (.ref_clk_i(ref_clk_i), .rst_n_i(rst_n_i),
  .cs_n_i(cs_n_i), .sample_tick_i(sample_tick_i), .port_data_i(port_data_i), .dac_code_o(dac_code_o),
  .outclk_tick_o(outclk_tick_o), .core_power_down_o(core_power_down_o),
  .device_power_down_o(device_power_down_o), .sample_clock_rx_off_o(sample_clock_rx_off_o),
  .pattern_enable_o(pattern_enable_o), .outclk_disable_o(outclk_disable_o),
  .port_a_rx_enable_o(port_a_rx_enable_o));

// ==== dcr_spi_host.sv ====
// Serial host model: command byte then data bytes, clock idle low
`timescale 1ns/10ps
module dcr_spi_host
(
  input wire logic ref_clk_i,
  input wire logic sdo_i,
  output logic sck_o,
  output logic cs_n_o,
  output logic sdi_o
);
  logic [7:0] rx_q[$];
  initial
  begin
    sck_o = 1'b0;
    cs_n_o = 1'b1;
    sdi_o = 1'b1;
  end
  // Four reference cycles a phase, four times the one cycle the slave needs to see a level
  task automatic phase();
    repeat (4) @(posedge ref_clk_i);
    #1;
  endtask
  task automatic frame(input logic [7:0] cmd, input logic [7:0] tx[$]);
    logic [7:0] b;
    logic [7:0] r;
    rx_q = {};
    cs_n_o = 1'b0;
    for (int i = 0; i <= tx.size(); i++)
    begin
      b = (i == 0) ? cmd : tx[i-1];
      for (int k = 7; k >= 0; k--)
      begin
        sdi_o = b[k];
        phase();
        sck_o = 1'b1;
        r[k] = sdo_i;
        phase();
        sck_o = 1'b0;
      end
      if (i > 0)
        rx_q.push_back(r);
    end
    phase();
    cs_n_o = 1'b1;
    // Released data line must not look like a held bit
    sdi_o = ~sdi_o;
    phase();
  endtask
endmodule

// ==== dcr_config_regs_tb_top.sv ====
// Self-checking bench for the configuration register bank
`timescale 1ns/10ps
module dcr_config_regs_tb_top
  import dcr_pkg::*;
;
  logic clk, rst_n, tick, scp, icp, sdo, sck, cs_n, sdi, otick;
  logic [15:0] pdata, dac;
  logic [1:0] aph;
  logic [7:0] cmp;
  wire [17:0] ctl;
  int bad_count = 0;
  int comparisons = 0;
  int cycles = 0;
  int c;
  logic [7:0] pb[$];
  logic [7:0] zq[$];
  logic [6:0] wa[9] = '{7'h00, 7'h02, 7'h03, 7'h04, 7'h05, 7'h1e, 7'h20, 7'h7f, 7'h06};
  logic [7:0] wd[9] = '{8'hff, 8'hde, 8'hff, 8'hf3, 8'hfe, 8'hfe, 8'hff, 8'hff, 8'hff};
  logic [7:0] we[9] = '{8'h00, 8'hd2, 8'h77, 8'h03, 8'h06, 8'h00, 8'h00, 8'h00, 8'ha5};
  dcr_spi_host host (.ref_clk_i(clk), .sdo_i(sdo), .sck_o(sck), .cs_n_o(cs_n), .sdi_o(sdi));
  dcr_config_regs #(.RESOLUTION_CODE(2'b01)) DUT (.ref_clk_i(clk), .rst_n_i(rst_n), .sck_i(sck),
    .cs_n_i(cs_n), .sdi_i(sdi), .sdo_o(sdo), .sample_tick_i(tick), .port_data_i(pdata), .dac_code_o(dac),
    .outclk_tick_o(otick), .sample_clock_present_i(scp), .inclk_present_i(icp), .sync_auto_phase_i(aph),
    .phase_comparator_bits_i(cmp), .outclk_disable_o(ctl[17]), .outclk_divider_select_o(ctl[16]),
    .outclk_drive_select_o(ctl[15]), .outclk_termination_o(ctl[14]), .inclk_rx_enable_o(ctl[13]),
    .inclk_quadrature_o(ctl[12]), .inclk_delay_adjust_o(ctl[11:9]), .port_a_rx_enable_o(ctl[8]),
    .port_b_rx_enable_o(ctl[7]), .single_port_select_o(ctl[6]), .sync_phase_select_o(ctl[5:4]),
    .pattern_enable_o(ctl[3]), .core_power_down_o(ctl[2]), .device_power_down_o(ctl[1]),
    .sample_clock_rx_off_o(ctl[0]));
  // ----------------------------------------
  // Tasks
  // ----------------------------------------
  task automatic end_sim();
    $display("comparisons %0d mismatches %0d", comparisons, bad_count);
    if (bad_count == 0 && comparisons > 0)
      $display("*** PASS ***");
    else
      $display("*** FAIL ***");
    $finish;
  endtask
  task automatic chk(input string nm, input logic [23:0] e, input logic [23:0] g);
    comparisons++;
    if (g !== e)
    begin
      bad_count++;
      $display("[FAIL] %s expected %h seen %h", nm, e, g);
    end
  endtask
  task automatic wr(input logic [6:0] a, input logic [7:0] d);
    logic [7:0] q[$];
    q.push_back(d);
    host.frame({1'b0, a}, q);
  endtask
  task automatic rd(input logic [6:0] a, input logic [7:0] e);
    logic [7:0] q[$];
    q.push_back(8'h00);
    host.frame({1'b1, a}, q);
    chk($sformatf("reg %h", a), 24'(e), 24'(host.rx_q[0]));
  endtask
  task automatic pulse();
    tick = 1'b1;
    @(posedge clk);
    #1;
    tick = 1'b0;
  endtask
  // Continuous sample ticks; counts output clock ticks seen
  task automatic tick_run(input int n);
    c = 0;
    tick = 1'b1;
    repeat (n)
    begin
      @(posedge clk);
      #1;
      c += int'(otick);
    end
    tick = 1'b0;
    @(posedge clk);
    #1;
  endtask
  // ----------------------------------------
  // Clock, timeout and sequence
  // ----------------------------------------
  initial
  begin
    clk = 1'b0;
    forever #10 clk = ~clk;
  end
  always @(posedge clk)
  begin
    cycles++;
    if (cycles == 40000)
    begin
      bad_count++;
      $display("[FAIL] run expected done seen hang");
      end_sim();
    end
  end
  initial
  begin
    rst_n = 1'b0;
    tick = 1'b0;
    pdata = 16'h0000;
    scp = 1'b1;
    icp = 1'b1;
    aph = 2'b01;
    cmp = 8'h00;
    repeat (8) @(posedge clk);
    #1;
    rst_n = 1'b1;
    rd(DCR_ADDR_PHASE_CMP, 8'h00);
    rd(DCR_ADDR_PAT_CTRL, 8'h00);
    rd(DCR_ADDR_PAT_DATA, 8'h00);
    rd(DCR_ADDR_RESET_POWER, 8'h10);
    cmp = 8'ha5;
    for (int i = 0; i < 9; i++)
      wr(wa[i], wd[i]);
    for (int i = 0; i < 9; i++)
      rd(wa[i], we[i]);
    chk("ctl", 24'({4'b1011, 2'b11, 3'h7, 3'b110, 2'b10, 4'h0}), 24'(ctl));
    wr(DCR_ADDR_SYNC, 8'h02);
    chk("sync", 24'h1, 24'(ctl[5:4]));
    wr(DCR_ADDR_CLOCK_IO, 8'h01);
    rd(DCR_ADDR_CLOCK_IO, 8'h01);
    scp = 1'b0;
    icp = 1'b0;
    wr(DCR_ADDR_CLOCK_IO, 8'h00);
    rd(DCR_ADDR_CLOCK_IO, 8'h00);
    rd(DCR_ADDR_INCLK, 8'h75);
    scp = 1'b1;
    icp = 1'b1;
    rd(DCR_ADDR_CLOCK_IO, 8'h02);
    wr(DCR_ADDR_RESET_POWER, 8'h02);
    rd(DCR_ADDR_RESET_POWER, 8'h12);
    chk("pd", 24'h4, 24'(ctl[2:0]));
    wr(DCR_ADDR_RESET_POWER, 8'h04);
    rd(DCR_ADDR_RESET_POWER, 8'h04);
    chk("pd", 24'h7, 24'(ctl[2:0]));
    wr(DCR_ADDR_RESET_POWER, 8'h07);
    chk("ctl", 24'h10, 24'(ctl));
    rd(DCR_ADDR_INCLK, 8'h00);
    rd(DCR_ADDR_RESET_POWER, 8'h10);
    for (int i = 0; i < 128; i++)
    begin
      pb.push_back(8'(i * 37 + 19));
      zq.push_back(8'h00);
    end
    host.frame({1'b0, DCR_ADDR_PAT_DATA}, pb);
    host.frame({1'b1, DCR_ADDR_PAT_DATA}, zq);
    for (int i = 0; i < 128; i++)
      chk("pat", 24'(pb[i]), 24'(host.rx_q[i]));
    rd(DCR_ADDR_PAT_DATA, pb[0]);
    rd(DCR_ADDR_PAT_DATA, pb[1]);
    wr(DCR_ADDR_DATA_PORT, 8'h08);
    wr(DCR_ADDR_PAT_CTRL, 8'h01);
    for (int k = 0; k < 6; k++)
    begin
      pulse();
      chk("dac", 24'({pb[2*k], pb[2*k+1]}), 24'(dac));
      @(posedge clk);
      #1;
    end
    tick_run(40);
    chk("ticks", 24'd10, 24'(c));
    wr(DCR_ADDR_PAT_CTRL, 8'h00);
    pdata = 16'h1234;
    wr(DCR_ADDR_CLOCK_IO, 8'h20);
    tick_run(40);
    chk("ticks", 24'd20, 24'(c));
    chk("dac", 24'h1234, 24'(dac));
    wr(DCR_ADDR_DATA_PORT, 8'h00);
    pulse();
    chk("dac", 24'h8000, 24'(dac));
    end_sim();
  end
endmodule
